// >>> hw/pcc_pkg.sv
package pcc_pkg;

  // sample and code carriers
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } pcc_lin_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } pcc_code_t;

  // code layout
  localparam int SIGN_POS = 7;
  localparam int SEG_HI = 6;
  localparam int SEG_LO = 4;
  localparam int STEP_HI = 3;
  localparam int STEP_LO = 0;
  localparam logic SIGN_POSITIVE = 1'b1;

  // a-law format
  localparam logic [7:0] A_EVEN_MASK = 8'h55;
  localparam logic [12:0] A_MAG_MAX = 13'h0FFF;
  localparam int A_SEG_SHIFT = 4;
  localparam logic [15:0] A_DEC_HALF = 16'h0008;
  localparam logic [15:0] A_DEC_OFFSET = 16'h0108;

  // mu-law format
  localparam logic [6:0] MU_MAG_MASK = 7'h7F;
  localparam logic [13:0] MU_MAG_MAX = 14'h1FDE;
  localparam logic [12:0] MU_BIAS = 13'h0021;
  localparam int MU_SEG_SHIFT = 5;
  localparam logic [15:0] MU_DEC_BIAS = 16'h0084;

  // reference points
  localparam logic [15:0] LIN_ZERO = 16'h0000;
  localparam logic [15:0] LIN_MAX = 16'h7FFF;
  localparam logic [7:0] A_CODE_ZERO = 8'hD5;
  localparam logic [7:0] A_CODE_MAX = 8'hAA;
  localparam logic [7:0] MU_CODE_ZERO = 8'hFF;

endpackage

// >>> hw/pcc_seg_find.sv
`timescale 1ns/1ps
module pcc_seg_find #(
  parameter int SHIFT = 4
) (
  input wire logic [12:0] value,
  output logic [2:0] seg
);
  // segment is the position of the leading one above the first segment
  always_comb begin
    seg = 3'h0;
    for (int i = SHIFT + 1; i <= SHIFT + 7; i++) begin
      if (value[i]) begin
        seg = 3'(i - SHIFT);
      end
    end
  end
endmodule // pcc_seg_find

// >>> hw/pcm_companding_codec.sv
`timescale 1ns/1ps
// Notes on behaviour
// - a-law sign bit one means positive
// - a-law curve mirrors exactly about zero
// - a-law codes carry even bits inverted
// - mu-law codes invert magnitude, keep sign
module pcc_codec
  import pcc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic law_is_mu,
  input wire pcc_lin_t enc_in,
  input wire pcc_code_t dec_in,
  output pcc_code_t enc_out,
  output pcc_lin_t dec_out
);

  ////////////////////////////////////////////////////////////////////////////
  // encoder magnitude
  logic sign_pos;
  logic [15:0] mag16;
  logic [12:0] a_mag;
  logic [13:0] m_clip;
  logic [12:0] m_bias;
  logic [2:0] a_seg;
  logic [2:0] m_seg;
  logic [3:0] a_step;
  logic [3:0] m_step;
  logic [7:0] a_plain;
  logic [7:0] next_code;

  assign sign_pos = ~enc_in.data[15];
  assign mag16 = enc_in.data[15] ? 16'(-enc_in.data) : enc_in.data;
  assign a_mag = (mag16[15:3] > A_MAG_MAX) ? A_MAG_MAX : mag16[15:3];
  assign m_clip = (mag16[15:2] > MU_MAG_MAX) ? MU_MAG_MAX : mag16[15:2];
  assign m_bias = 13'(m_clip[12:0] + MU_BIAS);

  pcc_seg_find #(.SHIFT(A_SEG_SHIFT)) u_seg_a (
    .value(a_mag),
    .seg(a_seg)
  );

  pcc_seg_find #(.SHIFT(MU_SEG_SHIFT)) u_seg_m (
    .value(m_bias),
    .seg(m_seg)
  );

  // step inside a segment, width doubling per segment except a-law segment 1, which has the width of segment 0
  assign a_step = 4'(a_mag >> ((a_seg == 3'h0) ? 3'h1 : a_seg));
  assign m_step = 4'(m_bias >> (4'(m_seg) + 4'h1));
  assign a_plain = {sign_pos, a_seg, a_step};

  always_comb begin
    if (law_is_mu) begin
      next_code = {sign_pos, ~{m_seg, m_step}};
    end else begin
      next_code = a_plain ^ A_EVEN_MASK;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enc_out <= '0;
    end else begin
      enc_out.valid <= enc_in.valid;
      enc_out.code <= next_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoder
  logic [7:0] a_raw;
  logic [6:0] m_raw;
  logic [15:0] a_lvl;
  logic [15:0] m_lvl;
  logic d_pos;
  logic [15:0] lvl;
  logic [15:0] next_sample;

  assign a_raw = dec_in.code ^ A_EVEN_MASK;
  assign m_raw = dec_in.code[SEG_HI:STEP_LO] ^ MU_MAG_MASK;
  assign d_pos = dec_in.code[SIGN_POS];

  always_comb begin
    a_lvl = {8'h00, a_raw[STEP_HI:STEP_LO], 4'h0};
    if (a_raw[SEG_HI:SEG_LO] == 3'h0) begin
      a_lvl = a_lvl + A_DEC_HALF;
    end else begin
      a_lvl = 16'((a_lvl + A_DEC_OFFSET) << (a_raw[SEG_HI:SEG_LO] - 3'h1));
    end
  end

  assign m_lvl = 16'((({9'h000, m_raw[STEP_HI:STEP_LO], 3'h0} + MU_DEC_BIAS) << m_raw[SEG_HI:SEG_LO])
    - MU_DEC_BIAS);
  assign lvl = law_is_mu ? m_lvl : a_lvl;
  assign next_sample = (d_pos == SIGN_POSITIVE) ? lvl : 16'(-lvl);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dec_out <= '0;
    end else begin
      dec_out.valid <= dec_in.valid;
      dec_out.data <= next_sample;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_a_sign;
    @(posedge clock) disable iff (rst)
    (enc_in.valid && !law_is_mu) |=> (enc_out.valid && enc_out.code[SIGN_POS] == !$past(enc_in.data[15]));
  endproperty
  a_a_sign: assert property (p_a_sign) else $error("a-law sign bit wrong");

  property p_a_mirror;
    @(posedge clock) disable iff (rst)
    (dec_in.valid && !law_is_mu) |=> (dec_out.data != LIN_ZERO)
      && (dec_out.data[15] == !$past(dec_in.code[SIGN_POS]));
  endproperty
  a_a_mirror: assert property (p_a_mirror) else $error("a-law decode not mirrored");

  property p_a_zero;
    @(posedge clock) disable iff (rst)
    (enc_in.valid && !law_is_mu && enc_in.data == LIN_ZERO) |=> (enc_out.code == A_CODE_ZERO);
  endproperty
  a_a_zero: assert property (p_a_zero) else $error("a-law even bits not inverted");

  property p_mu_zero;
    @(posedge clock) disable iff (rst)
    (enc_in.valid && law_is_mu && enc_in.data == LIN_ZERO) |=> (enc_out.code == MU_CODE_ZERO);
  endproperty
  a_mu_zero: assert property (p_mu_zero) else $error("mu-law magnitude not inverted");

  property p_mu_sign;
    @(posedge clock) disable iff (rst)
    (enc_in.valid && law_is_mu) ##1 (dec_in.valid && law_is_mu && dec_in.code == enc_out.code)
      |=> (dec_out.data[15] == $past(enc_in.data[15], 2)) || (dec_out.data == LIN_ZERO);
  endproperty
  a_mu_sign: assert property (p_mu_sign) else $error("mu-law sign inverted");

  property p_a_top;
    @(posedge clock) disable iff (rst)
    (enc_in.valid && !law_is_mu && enc_in.data == LIN_MAX) |=> (enc_out.code == A_CODE_MAX);
  endproperty
  a_a_top: assert property (p_a_top) else $error("a-law top segment wrong");

  property p_latency;
    @(posedge clock) disable iff (rst)
    enc_in.valid |=> enc_out.valid;
  endproperty
  a_latency: assert property (p_latency) else $error("encoder output late");

  ////////////////////////////////////////////////////////////////////////////
  // mirror, mu-law encoder sign and top code, and decoder checks
  property p_a_low;
    @(posedge clock) disable iff (rst)
    (enc_in.valid && !law_is_mu && enc_in.data == ~LIN_ZERO)
      |=> (enc_out.code == {~SIGN_POSITIVE, A_CODE_ZERO[SEG_HI:STEP_LO]});
  endproperty
  a_a_low: assert property (p_a_low) else $error("a-law smallest negative not mirrored");

  property p_a_bottom;
    @(posedge clock) disable iff (rst)
    (enc_in.valid && !law_is_mu && enc_in.data == ~LIN_MAX)
      |=> (enc_out.code == {~SIGN_POSITIVE, A_CODE_MAX[SEG_HI:STEP_LO]});
  endproperty
  a_a_bottom: assert property (p_a_bottom) else $error("a-law full negative not mirrored");

  property p_mu_enc_sign;
    @(posedge clock) disable iff (rst)
    (enc_in.valid && law_is_mu) |=> (enc_out.code[SIGN_POS] == !$past(enc_in.data[15]));
  endproperty
  a_mu_enc_sign: assert property (p_mu_enc_sign) else $error("mu-law encoded sign wrong");

  property p_mu_top;
    @(posedge clock) disable iff (rst)
    (enc_in.valid && law_is_mu && enc_in.data == LIN_MAX)
      |=> (enc_out.code == {SIGN_POSITIVE, ~MU_MAG_MASK});
  endproperty
  a_mu_top: assert property (p_mu_top) else $error("mu-law top code wrong");

  property p_mu_bottom;
    @(posedge clock) disable iff (rst)
    (enc_in.valid && law_is_mu && enc_in.data == ~LIN_MAX)
      |=> (enc_out.code == {~SIGN_POSITIVE, ~MU_MAG_MASK});
  endproperty
  a_mu_bottom: assert property (p_mu_bottom) else $error("mu-law full negative code wrong");

  property p_mu_low;
    @(posedge clock) disable iff (rst)
    (enc_in.valid && law_is_mu && enc_in.data == ~LIN_ZERO)
      |=> (enc_out.code == {~SIGN_POSITIVE, MU_CODE_ZERO[SEG_HI:STEP_LO]});
  endproperty
  a_mu_low: assert property (p_mu_low) else $error("mu-law smallest negative code wrong");

  property p_a_dec_zero;
    @(posedge clock) disable iff (rst)
    (dec_in.valid && !law_is_mu && dec_in.code == A_CODE_ZERO)
      |=> (dec_out.data == A_DEC_HALF);
  endproperty
  a_a_dec_zero: assert property (p_a_dec_zero) else $error("a-law zero code decoded wrong");

  property p_mu_dec_zero;
    @(posedge clock) disable iff (rst)
    (dec_in.valid && law_is_mu && dec_in.code == MU_CODE_ZERO)
      |=> (dec_out.data == LIN_ZERO);
  endproperty
  a_mu_dec_zero: assert property (p_mu_dec_zero) else $error("mu-law zero code decoded wrong");

  property p_mu_mirror;
    @(posedge clock) disable iff (rst)
    (dec_in.valid && law_is_mu)
      |=> (dec_out.data == LIN_ZERO) || (dec_out.data[15] == !$past(dec_in.code[SIGN_POS]));
  endproperty
  a_mu_mirror: assert property (p_mu_mirror) else $error("mu-law decoded sign wrong");

  property p_dec_latency;
    @(posedge clock) disable iff (rst)
    dec_in.valid |=> dec_out.valid;
  endproperty
  a_dec_latency: assert property (p_dec_latency) else $error("decoder output late");

  c_enc_a: cover property (@(posedge clock) disable iff (rst) enc_in.valid && !law_is_mu ##1 enc_out.valid);
  c_enc_mu: cover property (@(posedge clock) disable iff (rst) enc_in.valid && law_is_mu ##1 enc_out.valid);
  c_dec_a: cover property (@(posedge clock) disable iff (rst) dec_in.valid && !law_is_mu ##1 dec_out.valid);
  c_dec_mu: cover property (@(posedge clock) disable iff (rst) dec_in.valid && law_is_mu ##1 dec_out.valid);
  c_round: cover property (@(posedge clock) disable iff (rst) enc_in.valid ##1 dec_in.valid && dec_in.code == enc_out.code);

endmodule // pcc_codec

// >>> testbench/pcc_host.sv
`timescale 1ns/1ps
module pcc_host
  import pcc_pkg::*;
(
  input wire logic law_is_mu,
  input wire logic send,
  input wire logic [7:0] plain,
  output pcc_code_t dec_in
);
  // sign passes as is, a-law even bits or mu-law magnitude inverted; idle shows inverse
  logic [7:0] line_code;
  assign line_code = law_is_mu ? {plain[7], ~plain[6:0]} : plain ^ A_EVEN_MASK;
  assign dec_in = {send, send ? line_code : ~plain};
endmodule // pcc_host

// >>> testbench/pcm_companding_code_format_tb.sv
`timescale 1ns/1ps
module pcm_companding_code_format_tb
  import pcc_pkg::*;
;
  logic clock = 0, rst = 1, law_is_mu = 0, send = 0;
  logic [7:0] plain = 8'h00;
  logic [15:0] x;
  logic [7:0] rt_code, rt_plain;
  pcc_lin_t enc_in = '0, dec_out, a, b;
  pcc_code_t enc_out, dec_in;
  int error_cnt = 0, total_checks = 0;
  pcc_codec u_dut (.clock(clock), .rst(rst), .law_is_mu(law_is_mu), .enc_in(enc_in), .dec_in(dec_in),
    .enc_out(enc_out), .dec_out(dec_out));
  pcc_host u_host (.law_is_mu(law_is_mu), .send(send), .plain(plain), .dec_in(dec_in));
  initial begin
    forever #2 clock = ~clock;
  end
  ////////////////////////////////////////
  function automatic logic [7:0] exp_code(logic mu, logic [15:0] d);
    int xs, m, v, seg;
    xs = $signed(d);
    m = xs < 0 ? -xs : xs;
    seg = 0;
    if (mu) begin
      v = ((m >> 2) > 8158 ? 8158 : m >> 2) + 33;
      for (int i = 0; i < 7; i++) if (v >= (64 << i)) seg = i + 1;
      v = v >> (seg + 1);
      return {xs >= 0, ~seg[2:0], ~v[3:0]};
    end
    v = (m >> 3) > 4095 ? 4095 : m >> 3;
    for (int i = 0; i < 7; i++) if (v >= (32 << i)) seg = i + 1;
    v = seg < 2 ? v >> 1 : v >> seg;
    return {xs >= 0, seg[2:0], v[3:0]} ^ 8'h55;
  endfunction
  function automatic logic [15:0] exp_lin(logic mu, logic [7:0] p);
    int seg, lvl;
    seg = p[6:4];
    if (mu) lvl = ((p[3:0] * 8 + 132) << seg) - 132;
    else lvl = seg == 0 ? p[3:0] * 16 + 8 : (p[3:0] * 16 + 264) << (seg - 1);
    return p[7] ? 16'(lvl) : 16'(-lvl);
  endfunction
  task automatic check_code(pcc_code_t exp, pcc_code_t got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected enc_out expected %h seen %h", exp, got);
    end
  endtask
  task automatic check_lin(pcc_lin_t exp, pcc_lin_t got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected dec_out expected %h seen %h", exp, got);
    end
  endtask
  task automatic enc(logic mu, logic [15:0] d);
    law_is_mu = mu;
    enc_in = {1'b1, d};
    @(negedge clock);
    check_code({1'b1, exp_code(mu, d)}, enc_out);
  endtask
  task automatic dec(logic mu, logic [7:0] p, output pcc_lin_t y);
    law_is_mu = mu;
    plain = p;
    send = 1;
    @(negedge clock);
    y = dec_out;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(26239));
    repeat (20) @(negedge clock);
    rst = 0;
    enc(1'b0, 16'h0000);
    enc(1'b0, 16'h7FFF);
    enc(1'b0, 16'h8000);
    enc(1'b0, 16'hFFFF);
    enc(1'b1, 16'h0000);
    enc(1'b1, 16'h7FFF);
    enc(1'b1, 16'h8000);
    enc(1'b1, 16'hFFFF);
    for (int i = 0; i < 300; i++) begin
      x = 16'($urandom) >> (i % 14);
      x[2:0] = 3'h2;
      enc(1'(i % 2), x);
      enc(1'(i % 2), -x);
    end
    $display("test encode done");
    dec(1'b0, 8'h80, a);
    check_lin({1'b1, 16'h0008}, a);
    dec(1'b0, 8'hFF, a);
    check_lin({1'b1, 16'h7E00}, a);
    dec(1'b1, 8'h80, a);
    check_lin({1'b1, 16'h0000}, a);
    for (int i = 0; i < 200; i++) begin
      x = 16'($urandom);
      dec(1'(i % 2), {1'b1, x[6:0]}, a);
      check_lin({1'b1, exp_lin(1'(i % 2), {1'b1, x[6:0]})}, a);
      dec(1'(i % 2), {1'b0, x[6:0]}, b);
      check_lin({1'b1, exp_lin(1'(i % 2), {1'b0, x[6:0]})}, b);
    end
    $display("test decode done");
    for (int i = 0; i < 100; i++) begin
      x = 16'($urandom) >> (i % 14);
      if (i % 3 == 0) x = -x;
      rt_code = exp_code(1'(i % 2), x);
      rt_plain = (i % 2) ? {rt_code[7], ~rt_code[6:0]} : rt_code ^ A_EVEN_MASK;
      enc(1'(i % 2), x);
      dec(1'(i % 2), rt_plain, a);
      check_lin({1'b1, exp_lin(1'(i % 2), rt_plain)}, a);
    end
    $display("test round trip done");
    report_and_stop();
  end
  initial begin
    #20000;
    error_cnt++;
    report_and_stop();
  end
endmodule // pcm_companding_code_format_tb
